//--- hw/apc_pkg.sv
// constants, register map and carriers for the light/emitter configuration block
package apc_pkg;
  // fixed 7-bit bus address of the device
  localparam logic [6:0] I2C_ADDR = 7'h13;
  // register byte addresses
  localparam logic [7:0] ADDR_PART_IDENTITY = 8'h81;
  localparam logic [7:0] ADDR_UNUSED_LOCATION = 8'h82;
  localparam logic [7:0] ADDR_EMITTER_DRIVE_LEVEL = 8'h83;
  localparam logic [7:0] ADDR_LIGHT_MEASURE_PARAMS = 8'h84;
  // identity values, arbitrary neutral codes
  localparam logic [3:0] PART_CODE_VALUE = 4'hA;
  localparam logic [3:0] SILICON_STEP_VALUE = 4'h3;
  localparam logic [1:0] CAL_PROGRAM_VALUE = 2'h1;
  // emitter drive level layout: tag in 7:6, setting in 5:0
  localparam int CAL_TAG_LSB = 6;
  localparam int DRIVE_W = 6;
  localparam logic [5:0] DRIVE_RESET = 6'h02;
  localparam logic [5:0] DRIVE_MAX = 6'h14;
  localparam logic [7:0] DRIVE_STEP_MA = 8'h0A;
  // light parameter layout
  localparam int CONT_BIT = 7;
  localparam int OFFSET_BIT = 3;
  localparam int AVG_LSB = 0;
  localparam int AVG_W = 3;
  localparam logic CONT_RESET = 1'b0;
  localparam logic OFFSET_RESET = 1'b1;
  localparam logic [2:0] AVG_RESET = 3'h0;
  // accumulator width: 16-bit samples times up to 128
  localparam int ACC_W = 23;
  // register write strobe from the bus slave
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } apc_wr_t;
  // conversion request towards the light front end
  typedef struct packed {
    logic req;
    logic dark;
  } apc_conv_t;
endpackage : apc_pkg

//--- hw/apc_i2c_slave.sv
// i2c slave with register pointer, write strobe and read data fetch
`timescale 1ns/1ps
module apc_i2c_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output apc_pkg::apc_wr_t wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WRITE, S_WRITE_ACK, S_READ, S_READ_ACK
  } apc_i2c_state_t;

  logic [2:0] scl_s_q; // three-stage synchroniser
  logic [2:0] sda_s_q;
  logic scl_f_q; // filtered levels
  logic sda_f_q;
  logic scl_p_q; // previous filtered levels
  logic sda_p_q;
  apc_i2c_state_t st_q;
  logic [7:0] sh_q; // receive shift register
  logic [7:0] tx_q; // transmit shift register
  logic [3:0] cnt_q; // bits seen in current byte
  logic rw_q; // read transfer
  logic first_q; // next written byte is the pointer
  logic more_q; // master acked a read byte
  logic [7:0] ptr_q; // register pointer
  logic oe_q;
  logic sda_o_q;
  apc_pkg::apc_wr_t wr_q; // registered write strobe, address and data
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // synchronise pins; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // bus conditions on filtered levels
  assign start_c = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop_c = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  assign rise_c = scl_f_q & ~scl_p_q;
  assign fall_c = ~scl_f_q & scl_p_q;
  assign rd_addr = ptr_q;

  // protocol state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b1;
      more_q <= 1'b0;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
      wr_q <= '0;
    end else begin
      wr_q.wr <= 1'b0;
      if (start_c) begin
        // start or repeated start
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        first_q <= 1'b1;
        oe_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          S_IDLE: begin
            oe_q <= 1'b0;
          end
          S_ADDR, S_WRITE: begin
            // shift a byte in on rising edges
            if (rise_c && cnt_q != 4'h8) begin
              sh_q <= {sh_q[6:0], sda_f_q};
              cnt_q <= cnt_q + 4'h1;
            end
            if (fall_c && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == S_ADDR) begin
                // ack only our own address
                if (sh_q[7:1] == apc_pkg::I2C_ADDR) begin
                  oe_q <= 1'b1;
                  rw_q <= sh_q[0];
                  st_q <= S_ADDR_ACK;
                end else begin
                  st_q <= S_IDLE;
                end
              end else begin
                oe_q <= 1'b1;
                st_q <= S_WRITE_ACK;
                if (first_q) begin
                  ptr_q <= sh_q;
                  first_q <= 1'b0;
                end else begin
                  wr_q.wr <= 1'b1;
                  wr_q.addr <= ptr_q;
                  wr_q.data <= sh_q;
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          S_ADDR_ACK: begin
            if (fall_c) begin
              if (rw_q) begin
                // first read bit goes out at once
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                st_q <= S_READ;
              end else begin
                oe_q <= 1'b0;
                st_q <= S_WRITE;
              end
            end
          end
          S_WRITE_ACK: begin
            if (fall_c) begin
              oe_q <= 1'b0;
              st_q <= S_WRITE;
            end
          end
          S_READ: begin
            if (rise_c) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (fall_c) begin
              if (cnt_q == 4'h8) begin
                // byte sent: release for master ack
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
                st_q <= S_READ_ACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6];
              end
            end
          end
          S_READ_ACK: begin
            if (rise_c) begin
              more_q <= ~sda_f_q;
            end
            if (fall_c) begin
              if (more_q) begin
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                st_q <= S_READ;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // data line only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign wr = wr_q;
endmodule : apc_i2c_slave

//--- hw/apc_config_regs.sv
// identity, emitter drive and ambient light parameter registers with averaging engine
// Functional notes
// - identity register at 81h: part code, step
// - location 82h has no function
// - 83h sets emitter current for proximity only
// - drive setting times 10 mA, zero off
// - setting range 0..20, resets to 2
// - settings above 20 saturate at 200 mA
// - read-only calibration tag, writes ignored
// - 84h bit 7 continuous mode, default off
// - bit 3 offset compensation, default on
// - measure offset, subtract before storing result
// - bits 2:0 select 2^n averaged conversions
// - one-shot start runs full averaged sequence
`timescale 1ns/1ps
module apc_config_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic light_oneshot_start,
  input wire logic prox_active,
  output apc_pkg::apc_conv_t conv,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic [15:0] light_result,
  output logic light_result_valid,
  output logic [4:0] emitter_drive_applied,
  output logic [7:0] emitter_current_ma
);
  typedef enum logic [2:0] {
    E_IDLE, E_OFS_REQ, E_OFS_WAIT, E_SIG_REQ, E_SIG_WAIT, E_DONE
  } apc_eng_state_t;

  apc_pkg::apc_wr_t wr; // write strobe from bus slave
  logic [7:0] rd_addr; // read pointer from bus slave
  logic [7:0] rd_data; // read data for bus slave
  logic [5:0] emitter_drive_setting_q; // writable drive field
  logic cont_q; // continuous conversion enable
  logic offset_en_q; // offset compensation enable
  logic [2:0] avg_q; // averaging exponent
  logic [5:0] sat_c; // saturated drive code
  apc_eng_state_t est_q;
  logic [2:0] run_avg_q; // exponent latched for this run
  logic run_ofs_q; // offset enable latched for this run
  logic [7:0] left_q; // conversions left in run
  logic [15:0] ofs_q; // last measured offset
  logic [apc_pkg::ACC_W-1:0] acc_q; // running sum
  logic [15:0] diff_c; // compensated sample
  logic [apc_pkg::ACC_W-1:0] avg_c; // averaged sum
  apc_pkg::apc_conv_t conv_q;
  logic [15:0] result_q;
  logic valid_q;
  logic [4:0] applied_q;
  logic [7:0] ma_q;

  // bus slave
  apc_i2c_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // emitter drive setting register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emitter_drive_setting_q <= apc_pkg::DRIVE_RESET;
    end else if (wr.wr && wr.addr == apc_pkg::ADDR_EMITTER_DRIVE_LEVEL) begin
      // only the low field is stored; tag bits are dropped
      emitter_drive_setting_q <= wr.data[apc_pkg::DRIVE_W-1:0];
    end
  end

  // light parameter register; bits 6:4 are not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cont_q <= apc_pkg::CONT_RESET;
      offset_en_q <= apc_pkg::OFFSET_RESET;
      avg_q <= apc_pkg::AVG_RESET;
    end else if (wr.wr && wr.addr == apc_pkg::ADDR_LIGHT_MEASURE_PARAMS) begin
      cont_q <= wr.data[apc_pkg::CONT_BIT];
      offset_en_q <= wr.data[apc_pkg::OFFSET_BIT];
      avg_q <= wr.data[apc_pkg::AVG_LSB +: apc_pkg::AVG_W];
    end
  end

  // read multiplexer; unmapped and unused bits read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      apc_pkg::ADDR_PART_IDENTITY: begin
        rd_data = {apc_pkg::PART_CODE_VALUE, apc_pkg::SILICON_STEP_VALUE};
      end
      apc_pkg::ADDR_UNUSED_LOCATION: begin
        rd_data = 8'h00;
      end
      apc_pkg::ADDR_EMITTER_DRIVE_LEVEL: begin
        rd_data = {apc_pkg::CAL_PROGRAM_VALUE, emitter_drive_setting_q};
      end
      apc_pkg::ADDR_LIGHT_MEASURE_PARAMS: begin
        rd_data = {cont_q, 3'h0, offset_en_q, avg_q};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // clamp setting to the top of the valid range
  assign sat_c = (emitter_drive_setting_q > apc_pkg::DRIVE_MAX) ?
                 apc_pkg::DRIVE_MAX : emitter_drive_setting_q;

  // applied emitter current, live only during proximity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_q <= 5'h00;
      ma_q <= 8'h00;
    end else if (prox_active) begin
      applied_q <= sat_c[4:0];
      ma_q <= 8'(sat_c * apc_pkg::DRIVE_STEP_MA);
    end else begin
      applied_q <= 5'h00;
      ma_q <= 8'h00;
    end
  end

  // compensated sample clamps at zero
  assign diff_c = (conv_data > ofs_q) ? (conv_data - ofs_q) : 16'h0000;
  // sum divided by number of conversions
  assign avg_c = acc_q >> run_avg_q;

  // averaging and offset engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      est_q <= E_IDLE;
      run_avg_q <= 3'h0;
      run_ofs_q <= 1'b0;
      left_q <= 8'h00;
      ofs_q <= 16'h0000;
      acc_q <= '0;
      conv_q <= '0;
    end else begin
      conv_q.req <= 1'b0;
      unique case (est_q)
        E_IDLE: begin
          // a one-shot or continuous mode launches a run
          if (light_oneshot_start || cont_q) begin
            run_avg_q <= avg_q;
            run_ofs_q <= offset_en_q;
            left_q <= 8'(9'h001 << avg_q);
            acc_q <= '0;
            ofs_q <= 16'h0000;
            est_q <= offset_en_q ? E_OFS_REQ : E_SIG_REQ;
          end
        end
        E_OFS_REQ: begin
          // dark conversion before each light conversion
          conv_q.req <= 1'b1;
          conv_q.dark <= 1'b1;
          est_q <= E_OFS_WAIT;
        end
        E_OFS_WAIT: begin
          if (conv_done) begin
            ofs_q <= conv_data;
            est_q <= E_SIG_REQ;
          end
        end
        E_SIG_REQ: begin
          conv_q.req <= 1'b1;
          conv_q.dark <= 1'b0;
          est_q <= E_SIG_WAIT;
        end
        E_SIG_WAIT: begin
          if (conv_done) begin
            acc_q <= acc_q + apc_pkg::ACC_W'(diff_c);
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              est_q <= E_DONE;
            end else begin
              est_q <= run_ofs_q ? E_OFS_REQ : E_SIG_REQ;
            end
          end
        end
        E_DONE: begin
          est_q <= E_IDLE;
        end
        default: begin
          est_q <= E_IDLE;
        end
      endcase
    end
  end

  // only the averaged value reaches the result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (est_q == E_DONE);
      if (est_q == E_DONE) begin
        result_q <= avg_c[15:0];
      end
    end
  end

  assign conv = conv_q;
  assign light_result = result_q;
  assign light_result_valid = valid_q;
  assign emitter_drive_applied = applied_q;
  assign emitter_current_ma = ma_q;
endmodule : apc_config_regs

//--- testbench/apc_i2c_host.sv
// i2c host model that drives the bus pins and reads back the resolved data line
`timescale 1ns/1ps
module apc_i2c_host (
  input wire logic clk,
  output logic scl,
  output logic sda_q,
  input wire logic sda_line
);
  int nacks = 0; // bytes that nobody acknowledged
  initial begin
    scl = 1'b1;
    sda_q = 1'b1;
  end
  // wait a number of clock edges
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap
  // one bit: data moves in the low phase, the line is sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    gap(10);
    sda_q <= b;
    gap(12);
    scl <= 1'b1;
    gap(12);
    s = sda_line;
    gap(12);
  endtask : bit_io
  // start or repeated start: data falls while the clock is high
  task automatic start;
    logic s;
    bit_io(1'b1, s);
    sda_q <= 1'b0;
    gap(12);
  endtask : start
  // stop: data rises while the clock is high
  task automatic stop;
    logic s;
    bit_io(1'b0, s);
    sda_q <= 1'b1;
    gap(12);
  endtask : stop
  // eight bits out msb first, then the acknowledge slot
  task automatic byte_out(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask : byte_out
  // eight bits in msb first, then our acknowledge or refusal
  task automatic byte_in(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(ack_n, s);
  endtask : byte_in
  // pointer then one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    byte_out({apc_pkg::I2C_ADDR, 1'b0});
    byte_out(a);
    byte_out(d);
    stop();
  endtask : write_reg
  // pointer, repeated start, one byte refused at the end
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    start();
    byte_out({apc_pkg::I2C_ADDR, 1'b0});
    byte_out(a);
    start();
    byte_out({apc_pkg::I2C_ADDR, 1'b1});
    byte_in(1'b1, d);
    stop();
  endtask : read_reg
endmodule : apc_i2c_host

//--- testbench/apc_config_regs_asserts.sv
// concurrent checks on the ports of the configuration block
`timescale 1ns/1ps
module apc_config_regs_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic light_oneshot_start,
  input wire logic prox_active,
  input wire apc_pkg::apc_conv_t conv,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] light_result,
  input wire logic light_result_valid,
  input wire logic [4:0] emitter_drive_applied,
  input wire logic [7:0] emitter_current_ma
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // offset conversion answered
  sequence s_dark_done;
    conv_done && conv.dark;
  endsequence
  // light conversion asked for
  sequence s_light_req;
    conv.req && !conv.dark;
  endsequence
  a_dark_then_light: assert property (s_dark_done |-> ##[1:4] s_light_req)
    else $error("light request missing after offset conversion");
  a_req_one_cycle: assert property (conv.req |=> !conv.req)
    else $error("conversion request longer than one cycle");
  a_valid_one_cycle: assert property (light_result_valid |=> !light_result_valid)
    else $error("result valid longer than one cycle");
  a_valid_after_light: assert property (light_result_valid |->
    $past(conv_done, 2) && !$past(conv.dark, 2))
    else $error("result valid without a light conversion");
  a_result_holds: assert property (!light_result_valid |-> $stable(light_result))
    else $error("result moved without valid");
  a_drive_limit: assert property (emitter_drive_applied <= 5'h14)
    else $error("applied drive above maximum");
  a_current_scale: assert property (
    emitter_current_ma == 8'(emitter_drive_applied) * 8'h0A)
    else $error("current not ten times the setting");
  a_drive_off_idle: assert property (!prox_active |=>
    emitter_drive_applied == 5'h00 && emitter_current_ma == 8'h00)
    else $error("emitter driven outside proximity");
endmodule : apc_config_regs_asserts

//--- testbench/apc_config_regs_test.sv
// self-checking bench for the configuration block with host and front end models
`timescale 1ns/1ps
module apc_config_regs_test;
  logic clk = 1'b0;
  logic rst_n, start_q, prox_q, conv_done, scl, sda_q, sda_o, sda_oe, valid;
  logic [15:0] conv_data, result, fe_val, dark_v, light_v;
  logic [4:0] applied;
  logic [7:0] cur_ma, rd;
  apc_pkg::apc_conv_t conv;
  int fail_count = 0;
  int n_checks = 0;
  int fe_cnt = 0, n_dark = 0, n_light = 0, lat = 2;
  wire sda_line = sda_q & ~sda_oe; // pulled up, pulled low by either party
  always #2.5 clk = ~clk;
  apc_i2c_host apc_i2c_host_i (.clk(clk), .scl(scl), .sda_q(sda_q), .sda_line(sda_line));
  apc_config_regs apc_config_regs_i (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .light_oneshot_start(start_q), .prox_active(prox_q),
    .conv(conv), .conv_done(conv_done), .conv_data(conv_data), .light_result(result),
    .light_result_valid(valid), .emitter_drive_applied(applied), .emitter_current_ma(cur_ma));
  // front end: answers each request after lat cycles, data scrambled otherwise
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~fe_val;
    if (conv.req === 1'b1) begin
      fe_cnt = lat;
      fe_val = conv.dark ? dark_v : light_v + 16'(n_light);
      if (conv.dark) n_dark++;
      else n_light++;
    end else if (fe_cnt > 0) begin
      fe_cnt--;
      if (fe_cnt == 0) begin
        conv_done <= 1'b1;
        conv_data <= fe_val;
      end
    end
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // counts, verdict, end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // bounded wait for a result pulse
  task automatic wait_valid;
    int i;
    for (i = 0; i < 5000 && valid !== 1'b1; i++) @(negedge clk);
    if (i == 5000) begin
      fail_count++;
      $display("unexpected at %0t: no result", $time);
      end_sim();
    end
    @(negedge clk);
  endtask : wait_valid
  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apc_i2c_host_i.read_reg(a, rd);
    check(16'(rd), 16'(exp));
  endtask : rd_chk
  // reset values, unused location and unmapped address
  task automatic test_reset_values;
    rd_chk(8'h81, {apc_pkg::PART_CODE_VALUE, apc_pkg::SILICON_STEP_VALUE});
    rd_chk(8'h82, 8'h00);
    rd_chk(8'h83, 8'h42);
    rd_chk(8'h84, 8'h08);
    rd_chk(8'h90, 8'h00);
    $display("done: reset values");
  endtask : test_reset_values
  // drive setting across range, saturation and the read-only tag
  task automatic test_drive;
    logic [7:0] v[5] = '{8'h00, 8'h07, 8'h14, 8'h15, 8'hFF};
    logic [4:0] m;
    prox_q <= 1'b1;
    foreach (v[i]) begin
      apc_i2c_host_i.write_reg(8'h83, v[i]);
      m = (v[i][5:0] > 6'h14) ? 5'h14 : v[i][4:0];
      check(16'(applied), 16'(m));
      check(16'(cur_ma), 16'(m) * 16'h000A);
      rd_chk(8'h83, {apc_pkg::CAL_PROGRAM_VALUE, v[i][5:0]});
    end
    @(posedge clk) prox_q <= 1'b0;
    repeat (3) @(negedge clk);
    check(16'(applied), 16'h0000);
    check(16'(cur_ma), 16'h0000);
    $display("done: emitter drive");
  endtask : test_drive
  // one-shot run with a second start inside it that must be ignored
  task automatic run_light(input int n, input logic ofs, input logic [15:0] lt, dk);
    int sum, li;
    apc_i2c_host_i.write_reg(8'h84, {4'h0, ofs, 3'(n)});
    light_v = lt;
    dark_v = dk;
    n_dark = 0;
    n_light = 0;
    sum = 0;
    for (int k = 0; k < (1 << n); k++) begin
      li = int'(lt) + k - (ofs ? int'(dk) : 0);
      sum += (li < 0) ? 0 : li;
    end
    @(posedge clk) start_q <= 1'b1;
    @(posedge clk) start_q <= 1'b0;
    repeat (3) @(posedge clk);
    start_q <= 1'b1;
    @(posedge clk) start_q <= 1'b0;
    wait_valid();
    check(result, 16'(sum >> n));
    check(16'(n_light), 16'(1 << n));
    check(16'(n_dark), ofs ? 16'(1 << n) : 16'h0000);
    $display("done: light run n=%0d", n);
  endtask : run_light
  // continuous mode restarts by itself and stops when cleared
  task automatic test_continuous;
    int seen;
    light_v = 16'h0200;
    n_light = 0;
    apc_i2c_host_i.write_reg(8'h84, 8'h80);
    wait_valid();
    wait_valid();
    // runs repeat every few cycles, so the last sample taken is the result
    check(result, light_v + 16'(n_light) - 16'h0001);
    apc_i2c_host_i.write_reg(8'h84, 8'h08);
    repeat (200) @(posedge clk);
    seen = n_light;
    repeat (200) @(posedge clk);
    check(16'(n_light), 16'(seen));
    $display("done: continuous");
  endtask : test_continuous
  // read-only places ignore writes, other bus address is refused
  task automatic test_writes_ignored;
    apc_i2c_host_i.write_reg(8'h81, 8'hFF);
    apc_i2c_host_i.write_reg(8'h82, 8'hFF);
    apc_i2c_host_i.write_reg(8'h84, 8'hF7);
    rd_chk(8'h81, {apc_pkg::PART_CODE_VALUE, apc_pkg::SILICON_STEP_VALUE});
    rd_chk(8'h82, 8'h00);
    rd_chk(8'h84, 8'h87);
    apc_i2c_host_i.write_reg(8'h84, 8'h08);
    apc_i2c_host_i.start();
    apc_i2c_host_i.byte_out(8'h40);
    apc_i2c_host_i.stop();
    check(16'(apc_i2c_host_i.nacks), 16'h0001);
    $display("done: ignored writes");
  endtask : test_writes_ignored
  initial begin
    rst_n = 1'b0;
    start_q = 1'b0;
    prox_q = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    fe_val = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    test_reset_values();
    test_drive();
    run_light(0, 1'b1, 16'h0150, 16'h0030);
    lat = 3;
    run_light(2, 1'b1, 16'h0100, 16'h0101);
    lat = 1;
    run_light(7, 1'b1, 16'h1000, 16'h0040);
    run_light(1, 1'b0, 16'h0077, 16'h0500);
    test_continuous();
    test_writes_ignored();
    end_sim();
  end
endmodule : apc_config_regs_test
bind apc_config_regs apc_config_regs_asserts apc_config_regs_asserts_i (.clk(clk),
  .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .light_oneshot_start(light_oneshot_start), .prox_active(prox_active), .conv(conv),
  .conv_done(conv_done), .conv_data(conv_data), .light_result(light_result),
  .light_result_valid(light_result_valid), .emitter_drive_applied(emitter_drive_applied),
  .emitter_current_ma(emitter_current_ma));
